// ### logic/usb_rh_pkg.sv
/*
 root hub port status package: register addresses, field positions,
 reset values, timing constants and the carrier types.
 assumes a 125 MHz system clock and a single downstream port.
*/
package usb_rh_pkg;
    localparam logic [31:0] HUB_ADDR = 32'h9010_1050;
    localparam logic [31:0] PORT_ADDR = 32'h9010_1054;
    localparam logic [31:0] CFG_ADDR = 32'h9010_1058;
    localparam logic [31:0] IST_ADDR = 32'h9010_105c;
    localparam logic [31:0] ICLR_ADDR = 32'h9010_1060;
    localparam logic [31:0] IEN_ADDR = 32'h9010_1064;
    // hub word: clear global power / set global power
    localparam int H_CGP = 0;
    localparam int H_SGP = 16;
    // port word status bits; write meaning shares the position
    localparam int P_CCS = 0;
    localparam int P_PES = 1;
    localparam int P_PSS = 2;
    localparam int P_PORT_OVERCURRENT_FLAG = 3;
    localparam int P_PRS = 4;
    localparam int P_PPS = 8;
    localparam int P_LOW_SPEED_ATTACHED = 9;
    localparam int P_CHG = 16;
    // change flag index, word bit is P_CHG + index
    localparam int C_CSC = 0;
    localparam int C_PORT_ENABLE_CHANGE_FLAG = 1;
    localparam int C_PORT_RESUME_DONE_FLAG = 2;
    localparam int C_PORT_OVERCURRENT_CHANGE_FLAG = 3;
    localparam int C_PORT_RESET_DONE_FLAG = 4;
    // config word
    localparam int CF_SCHEME = 0;
    localparam int CF_MASK = 1;
    localparam int CF_FIXED = 2;
    localparam int CF_PPOC = 3;
    localparam logic [3:0] CFG_RST = 4'h0;
    localparam logic [4:0] IEN_RST = 5'h00;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // filtered pin index, follows pins_t packing
    localparam int PIN_WAKE = 0;
    localparam int PIN_ERR = 1;
    localparam int PIN_OC = 2;
    localparam int PIN_LS = 3;
    localparam int PIN_CONN = 4;
    localparam int CLK_MHZ = 125;
    localparam int CLK_NS = 8;
    localparam int RESET_TIME_US = 10000;
    localparam int RESUME_TIME_US = 20000;
    localparam int RESYNC_TIME_US = 3000;
    localparam int EOP_TIME_NS = 1333;
    localparam int RESET_CYC = RESET_TIME_US * CLK_MHZ;
    localparam int RESUME_CYC = RESUME_TIME_US * CLK_MHZ;
    localparam int RESYNC_CYC = RESYNC_TIME_US * CLK_MHZ;
    localparam int EOP_CYC = (EOP_TIME_NS + CLK_NS - 1) / CLK_NS;

    typedef enum logic [2:0] {
        PH_IDLE = 3'b000,
        PH_RESET = 3'b001,
        PH_RESUME = 3'b010,
        PH_EOP = 3'b011,
        PH_RESYNC = 3'b100
    } phase_t;

    typedef struct packed {
        logic connect;
        logic low_speed;
        logic overcurrent;
        logic port_error;
        logic remote_wake;
    } pins_t;

    typedef struct packed {
        logic power;
        logic reset;
        logic resume;
        logic eop;
        logic enable;
        logic suspend;
    } drive_t;
endpackage

// ### logic/usb_root_hub_port_status.sv
/*
 root hub status and port 1 status/change logic with an axi4-lite slave
 and one level interrupt.
 assumes pins arrive asynchronous to i_clk and i_xact_busy comes from the
 transaction engine on i_clk; i_rst_n doubles as root hub reset.
*/
// Contract
// - hub local power status bit always reads as zero
// - global mode: clear global power write of 1 powers off all ports
// - per-port mode: clear global power affects only unmasked ports
// - port write during a bus transaction is applied after it ends
// - port word: status in low half, change flags in high half
// - reset done flag set when 10 ms reset ends; write 1 clears
// - overcurrent change flag set on indicator change; write 1 clears
// - resume done flag set after resume pulse, eop and 3 ms resync
// - resume done flag cleared when reset done flag is set
// - enable change flag set when hardware clears port enable; an overcurrent power-off clears port enable without setting it
// - software clearing port enable never sets enable change flag
// - connect change flag set on connect or disconnect; write 1 clears
// - reset, enable or suspend command while disconnected sets connect change
// - fixed device port: connect change set only after root hub reset
// - per-port mode: set global power affects only unmasked ports
// - reset command on disconnected port starts no reset signalling
// - overcurrent clears port power
`timescale 1ns/1ps
module usb_root_hub_port_status
    import usb_rh_pkg::*;
#(
    parameter int RESET_CYCLES = RESET_CYC,
    parameter int RESUME_CYCLES = RESUME_CYC,
    parameter int RESYNC_CYCLES = RESYNC_CYC
) (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic [31:0] i_awaddr,
    input wire logic i_awvalid,
    output logic o_awready,
    input wire logic [31:0] i_wdata,
    input wire logic [3:0] i_wstrb,
    input wire logic i_wvalid,
    output logic o_wready,
    output logic [1:0] o_bresp,
    output logic o_bvalid,
    input wire logic i_bready,
    input wire logic [31:0] i_araddr,
    input wire logic i_arvalid,
    output logic o_arready,
    output logic [31:0] o_rdata,
    output logic [1:0] o_rresp,
    output logic o_rvalid,
    input wire logic i_rready,
    input wire pins_t i_pins,
    input wire logic i_xact_busy,
    output drive_t o_drive,
    output logic o_irq
);
    typedef struct packed {
        logic [4:0] s1;
        logic [4:0] s2;
        logic [4:0] s3;
        logic [4:0] f;
        logic ccs;
        logic port_enable_state;
        logic port_suspend_state;
        logic port_overcurrent_flag;
        logic port_reset_active;
        logic port_power_state;
        logic low_speed_attached;
        logic [4:0] chg;
        phase_t phase;
        logic [21:0] timer;
        logic armed;
        logic pend_v;
        logic [31:0] pend_d;
        logic [3:0] cfg;
        logic [4:0] ien;
        logic [4:0] ist;
        logic irq;
        logic aw_h;
        logic [31:0] aw_a;
        logic w_h;
        logic [31:0] w_d;
        logic [31:0] w_m;
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        drive_t drv;
    } state_t;

    state_t st_reg;
    state_t st_next;
    logic [4:0] ev;
    logic [4:0] clr;
    logic hub_wr;
    logic port_apply;
    logic w_go;
    logic scheme;
    logic mask;

    function automatic logic [31:0] strb_mask(input logic [3:0] s);
        return {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
    endfunction

    function automatic logic [31:0] port_word(input state_t s);
        logic [31:0] w;
        w = 32'h0000_0000;
        w[P_CHG +: 5] = s.chg;
        w[P_LOW_SPEED_ATTACHED] = s.low_speed_attached & s.ccs;
        w[P_PPS] = s.port_power_state;
        w[P_PRS] = s.port_reset_active;
        w[P_PORT_OVERCURRENT_FLAG] = s.port_overcurrent_flag;
        w[P_PSS] = s.port_suspend_state;
        w[P_PES] = s.port_enable_state;
        w[P_CCS] = s.ccs;
        return w;
    endfunction

    assign scheme = st_reg.cfg[CF_SCHEME];
    assign mask = st_reg.cfg[CF_MASK];
    assign w_go = st_reg.aw_h && st_reg.w_h && !st_reg.bvalid && !st_reg.pend_v;
    assign port_apply = st_reg.pend_v && !i_xact_busy;

    always_comb begin
        st_next = st_reg;
        ev = 5'h00;
        clr = 5'h00;
        hub_wr = 1'b0;
        // three-stage pin sync, a level counts once stages two and three agree
        st_next.s1 = i_pins;
        st_next.s2 = st_reg.s1;
        st_next.s3 = st_reg.s2;
        st_next.f = (~(st_reg.s2 ^ st_reg.s3) & st_reg.s3)
                  | ((st_reg.s2 ^ st_reg.s3) & st_reg.f);

        // bus slave
        if (i_awvalid && st_reg.awready) begin
            st_next.aw_h = 1'b1;
            st_next.aw_a = i_awaddr;
        end
        if (i_wvalid && st_reg.wready) begin
            st_next.w_h = 1'b1;
            st_next.w_m = strb_mask(i_wstrb);
            st_next.w_d = i_wdata & strb_mask(i_wstrb);
        end
        if (st_reg.bvalid && i_bready) begin
            st_next.bvalid = 1'b0;
        end
        // a second port write waits while one is still deferred
        if (w_go) begin
            st_next.aw_h = 1'b0;
            st_next.w_h = 1'b0;
            st_next.bvalid = 1'b1;
            st_next.bresp = RESP_OKAY;
            unique case (st_reg.aw_a)
                HUB_ADDR: hub_wr = 1'b1;
                PORT_ADDR: begin
                    st_next.pend_v = 1'b1;
                    st_next.pend_d = st_reg.w_d;
                end
                CFG_ADDR: st_next.cfg = (st_reg.cfg & ~st_reg.w_m[3:0]) | st_reg.w_d[3:0];
                IEN_ADDR: st_next.ien = (st_reg.ien & ~st_reg.w_m[4:0]) | st_reg.w_d[4:0];
                // irq clear acts on the irq status only, never on the port change flags
                ICLR_ADDR: ;
                IST_ADDR: ;
                default: st_next.bresp = RESP_SLVERR;
            endcase
        end
        st_next.awready = !st_next.aw_h;
        st_next.wready = !st_next.w_h;
        if (i_arvalid && st_reg.arready) begin
            st_next.arready = 1'b0;
            st_next.rvalid = 1'b1;
            st_next.rresp = RESP_OKAY;
            st_next.rdata = 32'h0000_0000;
            unique case (i_araddr)
                HUB_ADDR: st_next.rdata = 32'h0000_0000;
                PORT_ADDR: st_next.rdata = port_word(st_reg);
                CFG_ADDR: st_next.rdata = {28'h0000000, st_reg.cfg};
                IST_ADDR: st_next.rdata = {27'h0000000, st_reg.ist};
                IEN_ADDR: st_next.rdata = {27'h0000000, st_reg.ien};
                ICLR_ADDR: ;
                default: st_next.rresp = RESP_SLVERR;
            endcase
        end
        if (st_reg.rvalid && i_rready) begin
            st_next.rvalid = 1'b0;
            st_next.arready = 1'b1;
        end

        // connect tracking; a fixed device reports once, after root hub reset
        st_next.ccs = st_reg.f[PIN_CONN] && st_reg.port_power_state;
        st_next.low_speed_attached = st_reg.f[PIN_LS];
        if (st_reg.cfg[CF_FIXED]) begin
            if (st_reg.armed && st_next.ccs) begin
                ev[C_CSC] = 1'b1;
                st_next.armed = 1'b0;
            end
        end else if (st_next.ccs != st_reg.ccs) begin
            ev[C_CSC] = 1'b1;
        end
        if (st_reg.ccs && !st_next.ccs) begin
            if (st_reg.port_enable_state) begin
                ev[C_PORT_ENABLE_CHANGE_FLAG] = 1'b1;
            end
            st_next.port_enable_state = 1'b0;
            st_next.port_suspend_state = 1'b0;
            st_next.port_reset_active = 1'b0;
            st_next.phase = PH_IDLE;
        end
        if (st_reg.port_enable_state && st_reg.f[PIN_ERR]) begin
            st_next.port_enable_state = 1'b0;
            ev[C_PORT_ENABLE_CHANGE_FLAG] = 1'b1;
        end

        // overcurrent is reported per port only when so configured
        st_next.port_overcurrent_flag = st_reg.cfg[CF_PPOC] && st_reg.f[PIN_OC];
        if (st_next.port_overcurrent_flag != st_reg.port_overcurrent_flag) begin
            ev[C_PORT_OVERCURRENT_CHANGE_FLAG] = 1'b1;
        end

        // deferred port write
        if (port_apply) begin
            st_next.pend_v = 1'b0;
            clr = st_reg.pend_d[P_CHG +: 5];
            if (st_reg.pend_d[P_CCS]) begin
                st_next.port_enable_state = 1'b0;
            end
            if (st_reg.pend_d[P_PES] || st_reg.pend_d[P_PSS] || st_reg.pend_d[P_PRS]) begin
                if (!st_reg.ccs) begin
                    ev[C_CSC] = 1'b1;
                end
            end
            if (st_reg.ccs) begin
                if (st_reg.pend_d[P_PES]) begin
                    st_next.port_enable_state = 1'b1;
                end
                if (st_reg.pend_d[P_PSS] && st_reg.port_enable_state) begin
                    st_next.port_suspend_state = 1'b1;
                end
                if (st_reg.pend_d[P_PRS] && st_reg.phase == PH_IDLE) begin
                    st_next.port_reset_active = 1'b1;
                    st_next.phase = PH_RESET;
                    st_next.timer = 22'(RESET_CYCLES - 1);
                end
            end
            if (st_reg.pend_d[P_PORT_OVERCURRENT_FLAG] && st_reg.port_suspend_state && st_reg.phase == PH_IDLE) begin
                st_next.phase = PH_RESUME;
                st_next.timer = 22'(RESUME_CYCLES - 1);
            end
            // port power commands only work on masked ports in per-port mode
            if (scheme && mask && st_reg.pend_d[P_PPS]) begin
                st_next.port_power_state = 1'b1;
            end
            if (scheme && mask && st_reg.pend_d[P_LOW_SPEED_ATTACHED]) begin
                st_next.port_power_state = 1'b0;
            end
        end
        if (st_reg.port_suspend_state && st_reg.f[PIN_WAKE] && st_reg.phase == PH_IDLE) begin
            st_next.phase = PH_RESUME;
            st_next.timer = 22'(RESUME_CYCLES - 1);
        end

        // hub write acts at once; only bit 0 and bit 16 have effect
        if (hub_wr && (!scheme || !mask)) begin
            if (st_reg.w_d[H_CGP]) begin
                st_next.port_power_state = 1'b0;
            end
            if (st_reg.w_d[H_SGP]) begin
                st_next.port_power_state = 1'b1;
            end
        end

        // reset and resume sequencing share one down counter
        if (st_reg.phase != PH_IDLE && st_next.phase == st_reg.phase) begin
            if (st_reg.timer != 22'h000000) begin
                st_next.timer = st_reg.timer - 22'h000001;
            end else begin
                unique case (st_reg.phase)
                    PH_RESET: begin
                        st_next.port_reset_active = 1'b0;
                        st_next.port_enable_state = 1'b1;
                        st_next.phase = PH_IDLE;
                        ev[C_PORT_RESET_DONE_FLAG] = 1'b1;
                    end
                    PH_RESUME: begin
                        st_next.phase = PH_EOP;
                        st_next.timer = 22'(EOP_CYC - 1);
                    end
                    PH_EOP: begin
                        st_next.phase = PH_RESYNC;
                        st_next.timer = 22'(RESYNC_CYCLES - 1);
                    end
                    PH_RESYNC: begin
                        st_next.port_suspend_state = 1'b0;
                        st_next.phase = PH_IDLE;
                        ev[C_PORT_RESUME_DONE_FLAG] = 1'b1;
                    end
                    default: st_next.phase = PH_IDLE;
                endcase
            end
        end

        // overcurrent wins over any power-on write in the same cycle
        if (st_reg.f[PIN_OC]) begin
            st_next.port_power_state = 1'b0;
        end
        if (!st_next.port_power_state) begin
            st_next.port_enable_state = 1'b0;
            st_next.port_suspend_state = 1'b0;
            st_next.port_reset_active = 1'b0;
            st_next.phase = PH_IDLE;
        end

        // a set in the same cycle as its clear wins
        st_next.chg = (st_reg.chg & ~clr) | ev;
        if (ev[C_PORT_RESET_DONE_FLAG]) begin
            st_next.chg[C_PORT_RESUME_DONE_FLAG] = 1'b0;
        end
        st_next.ist = st_reg.ist | ev;
        if (w_go && st_reg.aw_a == ICLR_ADDR) begin
            st_next.ist = (st_reg.ist & ~st_reg.w_d[4:0]) | ev;
        end
        st_next.irq = |(st_next.ist & st_next.ien);
        st_next.drv = '{power: st_next.port_power_state,
                        reset: st_next.phase == PH_RESET,
                        resume: st_next.phase == PH_RESUME,
                        eop: st_next.phase == PH_EOP,
                        enable: st_next.port_enable_state,
                        suspend: st_next.port_suspend_state};
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            st_reg <= '0;
            st_reg.cfg <= CFG_RST;
            st_reg.ien <= IEN_RST;
            st_reg.armed <= 1'b1;
            st_reg.awready <= 1'b1;
            st_reg.wready <= 1'b1;
            st_reg.arready <= 1'b1;
        end else begin
            st_reg <= st_next;
        end
    end

    assign o_awready = st_reg.awready;
    assign o_wready = st_reg.wready;
    assign o_bvalid = st_reg.bvalid;
    assign o_bresp = st_reg.bresp;
    assign o_arready = st_reg.arready;
    assign o_rvalid = st_reg.rvalid;
    assign o_rdata = st_reg.rdata;
    assign o_rresp = st_reg.rresp;
    assign o_drive = st_reg.drv;
    assign o_irq = st_reg.irq;

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);

    lps_reads_zero_a: assert property (i_arvalid && o_arready && i_araddr == HUB_ADDR
        |=> o_rvalid && o_rdata[0] == 1'b0 && o_rdata[16] == 1'b0)
        else $error("hub read shows local power bit");
    global_off_a: assert property (hub_wr && st_reg.w_d[H_CGP] && !scheme && !st_reg.w_d[H_SGP]
        |=> !st_reg.port_power_state ##1 !o_drive.power)
        else $error("global power clear left port powered");
    masked_keep_a: assert property (hub_wr && scheme && mask && !st_reg.f[PIN_OC]
        |=> st_reg.port_power_state == $past(st_reg.port_power_state))
        else $error("global power write touched masked port");
    defer_hold_a: assert property (st_reg.pend_v && i_xact_busy
        |=> st_reg.pend_v && st_reg.pend_d == $past(st_reg.pend_d))
        else $error("port write applied during transaction");
    unused_bits_a: assert property (i_arvalid && o_arready && i_araddr == PORT_ADDR
        |=> o_rdata[31:21] == 11'h000 && o_rdata[15:10] == 6'h00 && o_rdata[7:5] == 3'h0)
        else $error("port word unused bits set");
    reset_done_a: assert property (st_reg.phase == PH_RESET && st_reg.timer == 22'h000000
        && st_reg.port_power_state && st_reg.ccs && st_reg.f[PIN_CONN] && !st_reg.f[PIN_OC]
        |=> st_reg.chg[C_PORT_RESET_DONE_FLAG] && !st_reg.chg[C_PORT_RESUME_DONE_FLAG] && !st_reg.port_reset_active ##1 o_drive.enable)
        else $error("reset end did not set reset done or clear resume done");
    resume_done_a: assert property (st_reg.phase == PH_EOP && st_reg.timer == 22'h000000
        && st_reg.ccs && st_reg.f[PIN_CONN] && !st_reg.f[PIN_OC] && st_reg.port_power_state
        |=> st_reg.phase == PH_RESYNC && (!st_reg.chg[C_PORT_RESUME_DONE_FLAG] || $past(st_reg.chg[C_PORT_RESUME_DONE_FLAG])))
        else $error("resume done flag set before resync");
    sw_disable_a: assert property (port_apply && st_reg.pend_d[P_CCS] && !st_reg.pend_d[P_PES]
        && !st_reg.pend_d[16 + C_PORT_ENABLE_CHANGE_FLAG] && !st_reg.chg[C_PORT_ENABLE_CHANGE_FLAG] && !st_reg.f[PIN_ERR]
        && st_reg.f[PIN_CONN] && st_reg.ccs && st_reg.port_power_state && !st_reg.f[PIN_OC]
        |=> !st_reg.chg[C_PORT_ENABLE_CHANGE_FLAG])
        else $error("software disable set enable change");
    hw_disable_a: assert property (st_reg.port_enable_state && st_reg.f[PIN_ERR]
        |=> st_reg.chg[C_PORT_ENABLE_CHANGE_FLAG] && !st_reg.port_enable_state)
        else $error("hardware disable missed enable change");
    dead_reset_a: assert property (port_apply && st_reg.pend_d[P_PRS] && !st_reg.ccs
        |=> st_reg.chg[C_CSC] && !st_reg.port_reset_active ##1 !o_drive.reset)
        else $error("reset of disconnected port misbehaved");
    oc_power_a: assert property (st_reg.f[PIN_OC] |=> !st_reg.port_power_state ##1 !o_drive.power)
        else $error("overcurrent left port powered");
    irq_level_a: assert property (|(ev & st_reg.ien) && !(w_go && st_reg.aw_a == IEN_ADDR)
        |=> o_irq)
        else $error("enabled event without interrupt");

    reset_seen_c: cover property (st_reg.phase == PH_RESET ##1 st_reg.chg[C_PORT_RESET_DONE_FLAG]);
    resume_seen_c: cover property (st_reg.phase == PH_RESYNC ##1 st_reg.chg[C_PORT_RESUME_DONE_FLAG]);
    defer_seen_c: cover property (st_reg.pend_v && i_xact_busy ##1 port_apply);
endmodule // usb_root_hub_port_status

// ### tb/usb_dev_model.sv
/*
 device model for the root hub port: turns the bench's attach, speed and
 fault controls into the port's pin levels.
 assumes one clock shared with the bench and o_drive from the port logic.
*/
`timescale 1ns/1ps
module usb_dev_model
    import usb_rh_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_attach,
    input wire logic i_slow,
    input wire logic i_oc,
    input wire logic i_err,
    input wire drive_t i_drive,
    output pins_t o_pins
);
    // self-powered device: its pull-up shows even with port power off
    always_ff @(posedge i_clk) begin
        o_pins.connect <= i_attach;
        o_pins.low_speed <= i_attach & i_slow;
        o_pins.overcurrent <= i_oc;
        // a bus error only means something while the port is enabled
        o_pins.port_error <= i_err & i_drive.enable;
        // limitation: remote wakeup is never signalled
        o_pins.remote_wake <= 1'b0;
    end
endmodule // usb_dev_model

// ### tb/usb_root_hub_port_status_bench.sv
/*
 self-checking bench for the root hub port status block.
 assumes usb_rh_pkg and usb_dev_model; short reset and resume counts.
*/
`timescale 1ns/1ps
module usb_root_hub_port_status_bench import usb_rh_pkg::*;;
    logic i_clk, i_rst_n, i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready, i_xact_busy;
    logic o_awready, o_wready, o_bvalid, o_arready, o_rvalid, o_irq, attach, slow, oc, err;
    logic [31:0] i_awaddr, i_wdata, i_araddr, o_rdata, d;
    logic [3:0] i_wstrb;
    logic [1:0] o_bresp, o_rresp, r;
    logic [31:0] cmd [3] = '{32'h2, 32'h4, 32'h10};
    pins_t i_pins;
    drive_t o_drive;
    int fail_count = 0;
    int n_checks = 0;
    int cyc = 0;
    usb_root_hub_port_status #(.RESET_CYCLES(20), .RESUME_CYCLES(20), .RESYNC_CYCLES(10))
    u_dut (.i_clk, .i_rst_n, .i_awaddr, .i_awvalid, .o_awready, .i_wdata, .i_wstrb,
        .i_wvalid, .o_wready, .o_bresp, .o_bvalid, .i_bready, .i_araddr, .i_arvalid,
        .o_arready, .o_rdata, .o_rresp, .o_rvalid, .i_rready, .i_pins, .i_xact_busy,
        .o_drive, .o_irq);
    usb_dev_model u_dev (.i_clk, .i_attach(attach), .i_slow(slow), .i_oc(oc), .i_err(err),
        .i_drive(o_drive), .o_pins(i_pins));
    initial begin
        i_clk = 1'b0;
        forever #4 i_clk = ~i_clk;
    end
    task conclude;
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    // the run is under a thousand cycles; this only cuts a hang short
    always @(posedge i_clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            fail_count++;
            conclude();
        end
    end
    task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
        n_checks++;
        if (s !== e) begin
            fail_count++;
            $display("[FAIL] %s expected %h seen %h", nm, e, s);
        end
    endtask
    task w(input int n);
        repeat (n) @(posedge i_clk);
    endtask
    task wr(input logic [31:0] a, input logic [31:0] dat, input logic [1:0] e);
        @(posedge i_clk);
        i_awaddr <= a;
        i_wdata <= dat;
        i_awvalid <= 1'b1;
        i_wvalid <= 1'b1;
        i_bready <= 1'b1;
        do begin
            @(posedge i_clk);
            if (o_awready === 1'b1) i_awvalid <= 1'b0;
            if (o_wready === 1'b1) i_wvalid <= 1'b0;
        end while (o_bvalid !== 1'b1);
        chk("bresp", 32'(o_bresp), 32'(e));
        i_bready <= 1'b0;
    endtask
    task wo(input logic [31:0] a, input logic [31:0] dat);
        wr(a, dat, RESP_OKAY);
    endtask
    task rd(input logic [31:0] a, output logic [31:0] q);
        @(posedge i_clk);
        i_araddr <= a;
        i_arvalid <= 1'b1;
        i_rready <= 1'b1;
        do begin
            @(posedge i_clk);
            if (o_arready === 1'b1) i_arvalid <= 1'b0;
        end while (o_rvalid !== 1'b1);
        q = o_rdata;
        r = o_rresp;
        i_rready <= 1'b0;
    endtask
    task pt(input logic [31:0] m, input logic [31:0] e);
        rd(PORT_ADDR, d);
        chk("port", d & m, e);
    endtask
    task rst;
        @(posedge i_clk);
        i_rst_n <= 1'b0;
        w(10);
        i_rst_n <= 1'b1;
    endtask
    task s_hub;
        rd(HUB_ADDR, d);
        chk("hub", d, 32'h0);
        rd(CFG_ADDR, d);
        chk("cfg", d, 32'h0);
        pt(32'hffff_ffff, 32'h0);
        rd(32'h9010_1070, d);
        chk("rresp", 32'(r), 32'(RESP_SLVERR));
        wr(32'h9010_1070, 32'h1, RESP_SLVERR);
        wo(HUB_ADDR, 32'h1_0000);
        pt(32'h100, 32'h100);
        wo(HUB_ADDR, 32'h0);
        pt(32'h100, 32'h100);
        wo(HUB_ADDR, 32'h1);
        pt(32'h100, 32'h0);
        chk("power", 32'(o_drive.power), 32'h0);
    endtask
    task s_ppm;
        wo(HUB_ADDR, 32'h1_0000);
        wo(CFG_ADDR, 32'h3);
        wo(HUB_ADDR, 32'h1);
        pt(32'h100, 32'h100);
        wo(PORT_ADDR, 32'h200);
        wo(HUB_ADDR, 32'h1_0000);
        pt(32'h100, 32'h0);
        wo(CFG_ADDR, 32'h1);
        wo(HUB_ADDR, 32'h1_0000);
        pt(32'h100, 32'h100);
        wo(HUB_ADDR, 32'h1);
        pt(32'h100, 32'h0);
        wo(CFG_ADDR, 32'h0);
        wo(HUB_ADDR, 32'h1_0000);
    endtask
    task s_disc;
        foreach (cmd[i]) begin
            wo(PORT_ADDR, cmd[i]);
            pt(32'h1_0017, 32'h1_0000);
            wo(PORT_ADDR, 32'h0);
            pt(32'h1_0000, 32'h1_0000);
            wo(PORT_ADDR, 32'h1_0000);
            pt(32'h1_0000, 32'h0);
        end
    endtask
    task s_conn;
        attach <= 1'b1;
        slow <= 1'b1;
        w(8);
        pt(32'hffff_ffff, 32'h1_0301);
        wo(PORT_ADDR, 32'h1_0000);
        attach <= 1'b0;
        w(8);
        pt(32'h1_0001, 32'h1_0000);
        attach <= 1'b1;
        w(8);
        wo(PORT_ADDR, 32'h1_0000);
    endtask
    task s_irq;
        wo(IST_ADDR, 32'h0);
        rd(IST_ADDR, d);
        chk("ist", d & 32'h1, 32'h1);
        chk("irq", 32'(o_irq), 32'h0);
        wo(IEN_ADDR, 32'h1);
        w(2);
        chk("irq", 32'(o_irq), 32'h1);
        wo(ICLR_ADDR, 32'h1);
        w(2);
        chk("irq", 32'(o_irq), 32'h0);
        wo(IEN_ADDR, 32'h0);
    endtask
    task s_rsm;
        wo(PORT_ADDR, 32'h10);
        pt(32'h1f_0010, 32'h10);
        chk("reset pin", 32'(o_drive.reset), 32'h1);
        w(40);
        pt(32'h1f_0012, 32'h10_0002);
        wo(PORT_ADDR, 32'h4);
        wo(PORT_ADDR, 32'h8);
        pt(32'h4_0000, 32'h0);
        chk("resume pin", 32'(o_drive.resume), 32'h1);
        chk("suspend pin", 32'(o_drive.suspend), 32'h1);
        w(250);
        pt(32'h4_0004, 32'h4_0000);
        wo(PORT_ADDR, 32'h0);
        pt(32'h10_0000, 32'h10_0000);
        wo(PORT_ADDR, 32'h10_0000);
        pt(32'h10_0000, 32'h0);
        wo(PORT_ADDR, 32'h10);
        w(40);
        pt(32'h14_0000, 32'h10_0000);
    endtask
    task s_en;
        err <= 1'b1;
        w(8);
        err <= 1'b0;
        pt(32'h2_0002, 32'h2_0000);
        wo(PORT_ADDR, 32'h2_0000);
        wo(PORT_ADDR, 32'h2);
        wo(PORT_ADDR, 32'h1);
        pt(32'h2_0002, 32'h0);
    endtask
    task s_oc;
        wo(CFG_ADDR, 32'h8);
        oc <= 1'b1;
        w(8);
        pt(32'h8_0108, 32'h8_0008);
        wo(PORT_ADDR, 32'h8_0000);
        pt(32'h8_0000, 32'h0);
        oc <= 1'b0;
        w(8);
        pt(32'h8_0008, 32'h8_0000);
    endtask
    task s_defer;
        attach <= 1'b0;
        w(8);
        i_xact_busy <= 1'b1;
        fork
            wo(PORT_ADDR, 32'h1_0000);
            begin
                w(30);
                pt(32'h1_0000, 32'h1_0000);
                i_xact_busy <= 1'b0;
            end
        join
        pt(32'h1_0000, 32'h0);
    endtask
    task s_fix;
        rst();
        wo(CFG_ADDR, 32'h4);
        // port power is off after root hub reset; no connect shows without it
        wo(HUB_ADDR, 32'h1_0000);
        attach <= 1'b1;
        w(8);
        pt(32'h1_0000, 32'h1_0000);
        wo(PORT_ADDR, 32'h1_0000);
        attach <= 1'b0;
        w(8);
        pt(32'h1_0000, 32'h0);
    endtask
    initial begin
        i_rst_n = 1'b0;
        i_wstrb = 4'hf;
        {i_awaddr, i_wdata, i_araddr} = '0;
        {i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready, i_xact_busy} = '0;
        {attach, slow, oc, err} = '0;
        rst();
        s_hub();
        s_ppm();
        s_disc();
        s_conn();
        s_irq();
        s_rsm();
        s_en();
        s_oc();
        s_defer();
        s_fix();
        conclude();
    end
endmodule // usb_root_hub_port_status_bench
